// ===== common/sbs_pkg.sv
// Shared constants and types of the synchronous burst memory port.
package sbs_pkg;
   localparam int ADDR_W     = 19;
   localparam int DEPTH      = 524288;
   localparam int LANES      = 4;
   localparam int LANE_W     = 9;
   localparam int DATA_W     = LANES * LANE_W;
   localparam int CNT_W      = 2;
   localparam int HI_W       = ADDR_W - CNT_W;
   localparam logic MODE_LINEAR = 1'b0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;

   // Burst pointer: upper address, seed of the low bits and the burst count.
   typedef struct packed {
      logic [HI_W-1:0]  hi;
      logic [CNT_W-1:0] seed;
      logic [CNT_W-1:0] cnt;
   } sbs_ptr_t;

   // Write controls as sampled at one edge.
   typedef struct packed {
      logic             global_n;
      logic             byte_en_n;
      logic [LANES-1:0] lane_sel_n;
   } sbs_wr_ctl_t;
endpackage

// ===== verilog/sbs_port.sv
// Synchronous flow-through burst memory port with its storage array.
`timescale 1ns/1ps

// Operation
// - Capture address on strobe with chip selected
// - Two low address bits seed burst counter
// - Lane select writes only with byte enable
// - Global write writes all lanes
// - Advance low steps burst counter each edge
// - Selected when a low, b high, c low
// - Processor strobe ignored while select a high
// - Output enable low drives data pins
// - Mask outputs first read clock after deselect
// - Both strobes: processor strobe wins
// - Accepted strobe loads address and counter
// - Strap low linear, high interleaved, static
// - Sleep input idles device, keeps contents
// - Capture input data, output registered read
// - Scan output changes on test clock fall
// - Interleaved XOR or linear add, wrapping
// - Processor strobe cycle ignores writes, advance
// - Controller strobe writes same cycle
// - Write cycle tri-states data outputs
module sbs_port
   import sbs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              proc_addr_strobe_n,
   input  wire logic              ctrl_addr_strobe_n,
   input  wire logic              burst_advance_n,
   input  wire logic              chip_sel_a_n,
   input  wire logic              chip_sel_b,
   input  wire logic              chip_sel_c_n,
   input  wire logic              global_write_n,
   input  wire logic              byte_write_en_n,
   input  wire logic              lane0_write_sel_n,
   input  wire logic              lane1_write_sel_n,
   input  wire logic              lane2_write_sel_n,
   input  wire logic              lane3_write_sel_n,
   input  wire logic              out_en_n,
   input  wire logic              burst_mode,
   input  wire logic              sleep_req,
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   data_oe_n,
   output logic                   sleep_active,
   input  wire logic              test_clk,
   input  wire logic              test_data_in,
   output logic                   test_data_out,
   output logic                   test_data_oe_n
);

   logic [DATA_W-1:0] rd_word;

   sbs_ptr_t          ptr_r, ptr_nxt;
   logic              active_r, active_nxt;
   logic              mask_r, mask_nxt;
   logic              wr_cyc_r, wr_cyc_nxt;
   logic [DATA_W-1:0] rd_r, rd_nxt;
   logic              mode_r, mode_nxt;
   logic              mode_done_r, mode_done_nxt;
   logic              tck_s1_r, tck_s2_r, tck_s3_r;
   logic              tdi_cap_r, tdi_cap_nxt;
   logic              tdo_r, tdo_nxt;

   sbs_wr_ctl_t       wctl;
   logic              selected;
   logic              p_go;
   logic              c_go;
   logic              load;
   logic              deselect;
   logic              cont;
   logic              wr_req;
   logic              do_write;
   logic              rd_go;
   logic [LANES-1:0]  lane_we;
   logic [CNT_W-1:0]  step_cnt;
   logic [CNT_W-1:0]  low_bits;
   logic [ADDR_W-1:0] acc_addr;
   sbs_ptr_t          acc_ptr;

   assign wctl = '{global_n:   global_write_n,
                   byte_en_n:  byte_write_en_n,
                   lane_sel_n: {lane3_write_sel_n, lane2_write_sel_n,
                                lane1_write_sel_n, lane0_write_sel_n}};

   // Access decode for this edge; sleep suppresses every access.
   // A processor strobe never writes at its own edge; its data comes one cycle later.
   always_comb begin
      selected = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
      p_go     = ~proc_addr_strobe_n & ~chip_sel_a_n & ~sleep_req;
      c_go     = ~ctrl_addr_strobe_n & ~p_go & ~sleep_req;
      load     = (p_go | c_go) & selected;
      deselect = (p_go | c_go) & ~selected;
      cont     = ~p_go & ~c_go & active_r & ~sleep_req;
      // Global write outranks the lane selects and the byte enable.
      if (~wctl.global_n) begin
         lane_we = {LANES{1'b1}};
      end else if (~wctl.byte_en_n) begin
         lane_we = ~wctl.lane_sel_n;
      end else begin
         lane_we = '0;
      end
      wr_req   = |lane_we;
      do_write = wr_req & ((load & c_go) | cont);
      rd_go    = (load & ~do_write) | (cont & ~wr_req & ~burst_advance_n);
   end

   // Burst pointer update and the address used at this edge.
   // Seed and count stay apart, so both burst orders are formed from the same two fields.
   always_comb begin
      ptr_nxt = ptr_r;
      if (load) begin
         ptr_nxt.hi   = addr[ADDR_W-1:CNT_W];
         ptr_nxt.seed = addr[CNT_W-1:0];
         ptr_nxt.cnt  = CNT_ZERO;
      end else if (cont & ~burst_advance_n) begin
         ptr_nxt.cnt  = CNT_W'(ptr_r.cnt + CNT_ONE);
      end
      acc_ptr = (load | cont) ? ptr_nxt : ptr_r;
      if (mode_r == MODE_LINEAR) begin
         step_cnt = CNT_W'(acc_ptr.seed + acc_ptr.cnt);
      end else begin
         step_cnt = acc_ptr.seed ^ acc_ptr.cnt;
      end
      low_bits = step_cnt;
      acc_addr = {acc_ptr.hi, low_bits};
   end

   // Selection state, output masking and registered read data.
   // Masking the first read after a deselect gives a turned-around bus one quiet cycle.
   always_comb begin
      active_nxt = active_r;
      if (load) begin
         active_nxt = 1'b1;
      end else if (deselect | sleep_req) begin
         active_nxt = 1'b0;
      end
      mask_nxt   = load & ~do_write & ~active_r;
      wr_cyc_nxt = do_write;
      rd_nxt     = rd_go ? rd_word : rd_r;
   end

   // The strap is caught once after reset; later changes are not followed.
   // A user who moves the strap must pass through reset again.
   always_comb begin
      mode_nxt      = mode_done_r ? mode_r : burst_mode;
      mode_done_nxt = 1'b1;
   end

   // Scan path: sampled on a test clock rise, shown on the following fall.
   // The test clock is far slower than clk, so its edges are found after synchronising.
   always_comb begin
      tdi_cap_nxt = (tck_s2_r & ~tck_s3_r) ? test_data_in : tdi_cap_r;
      tdo_nxt     = (~tck_s2_r & tck_s3_r) ? tdi_cap_r : tdo_r;
   end

   // Every piece of control state is registered here and nowhere else.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r       <= '0;
         active_r    <= 1'b0;
         mask_r      <= 1'b0;
         wr_cyc_r    <= 1'b0;
         rd_r        <= '0;
         mode_r      <= 1'b1;
         mode_done_r <= 1'b0;
         tck_s1_r    <= 1'b0;
         tck_s2_r    <= 1'b0;
         tck_s3_r    <= 1'b0;
         tdi_cap_r   <= 1'b0;
         tdo_r       <= 1'b0;
      end else begin
         ptr_r       <= ptr_nxt;
         active_r    <= active_nxt;
         mask_r      <= mask_nxt;
         wr_cyc_r    <= wr_cyc_nxt;
         rd_r        <= rd_nxt;
         mode_r      <= mode_nxt;
         mode_done_r <= mode_done_nxt;
         tck_s1_r    <= test_clk;
         tck_s2_r    <= tck_s1_r;
         tck_s3_r    <= tck_s2_r;
         tdi_cap_r   <= tdi_cap_nxt;
         tdo_r       <= tdo_nxt;
      end
   end

   // Storage has no reset so that contents survive sleep and reset alike.
   // Each lane owns its array, so that every array has a single writing process.
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] mem [0:DEPTH-1];
         always_ff @(posedge clk) begin
            if (do_write && lane_we[g]) begin
               mem[acc_addr] <= data_in[g*LANE_W +: LANE_W];
            end
         end

         assign rd_word[g*LANE_W +: LANE_W] = mem[acc_addr];
      end
   endgenerate

   // The enable is combinational because the output-enable pin acts without the clock.
   // Live write controls also release the bus, so the controller may drive write data early.
   always_comb begin
      data_oe_n = ~(~out_en_n & active_r & ~mask_r & ~wr_cyc_r
                    & ~(wr_req & active_r) & ~sleep_req);
   end

   assign data_out       = rd_r;
   // Sleep status follows the pin at once; there is no entry or exit delay.
   assign sleep_active   = sleep_req;
   assign test_data_out  = tdo_r;
   // The serial output is never released, as no scan state machine exists to do so.
   assign test_data_oe_n = 1'b0;

endmodule // sbs_port

// ===== dv/sbs_port_chk.sv
// Pin level checks of the burst memory port.
`timescale 1ns/1ps
module sbs_port_chk
   import sbs_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              proc_addr_strobe_n,
   input wire logic              ctrl_addr_strobe_n,
   input wire logic              burst_advance_n,
   input wire logic              chip_sel_a_n,
   input wire logic              chip_sel_b,
   input wire logic              chip_sel_c_n,
   input wire logic              global_write_n,
   input wire logic              byte_write_en_n,
   input wire logic              out_en_n,
   input wire logic              sleep_req,
   input wire logic              test_clk,
   input wire logic              data_oe_n,
   input wire logic              sleep_active,
   input wire logic              test_data_out,
   input wire logic [DATA_W-1:0] data_out
);
   wire sel  = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
   wire go   = !sleep_req && (!ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_sel_a_n));
   wire nowr = global_write_n && byte_write_en_n;
   wire rd   = go && sel && nowr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_sleep; sleep_active == sleep_req; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flag wrong");
   property p_sleep_oe; sleep_req |-> data_oe_n; endproperty
   a_sleep_oe: assert property (p_sleep_oe) else $error("pins driven in sleep");
   property p_oe; out_en_n |-> data_oe_n; endproperty
   a_oe: assert property (p_oe) else $error("pins driven with enable off");
   property p_wr; !ctrl_addr_strobe_n && proc_addr_strobe_n && sel && !global_write_n
      && !sleep_req |=> data_oe_n; endproperty
   a_wr: assert property (p_wr) else $error("pins driven after write");
   property p_mask; go && !sel ##1 rd |=> data_oe_n; endproperty
   a_mask: assert property (p_mask) else $error("first read not masked");
   property p_hold; !go && burst_advance_n && nowr && !sleep_req |=> $stable(data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved without access");
   property p_pign; !proc_addr_strobe_n && chip_sel_a_n && ctrl_addr_strobe_n
      && burst_advance_n && !sleep_req |=> $stable(data_out); endproperty
   a_pign: assert property (p_pign) else $error("strobe taken while unselected");
   property p_scan; $changed(test_data_out) |-> !test_clk && !$past(test_clk); endproperty
   a_scan: assert property (p_scan) else $error("scan out moved off falling edge");
   property p_rd; rd ##1 (rd && !out_en_n) |=> !data_oe_n || out_en_n || sleep_req || !nowr;
   endproperty
   a_rd: assert property (p_rd) else $error("read data not driven");
endmodule // sbs_port_chk

bind sbs_port sbs_port_chk i_sbs_port_chk (.*);

// ===== dv/sbs_bus_model.sv
// Controller model that drives the memory port bus.
`timescale 1ns/1ps
module sbs_bus_model
   import sbs_pkg::*;
(
   input  wire logic              clk,
   output logic      [ADDR_W-1:0] addr,
   output logic      [5:0]        ctl,
   output sbs_wr_ctl_t            wr,
   output logic      [DATA_W-1:0] data_in
);
   initial begin
      addr = '0;
      ctl = 6'h38;
      wr = 6'h3F;
      data_in = '0;
   end
   // Released data lines toggle, so stale data never looks valid.
   task automatic drive(logic [5:0] c, sbs_wr_ctl_t w, logic [ADDR_W-1:0] a,
                        logic [DATA_W-1:0] d);
      @(posedge clk);
      #1;
      ctl = c;
      addr = a;
      wr = w;
      data_in = (w.global_n && w.byte_en_n) ? ~data_in : d;
      #1;
   endtask
endmodule // sbs_bus_model

// ===== dv/tb_top.sv
// Self-checking bench of the burst memory port.
`timescale 1ns/1ps
module tb_top;
   import sbs_pkg::*;
   typedef struct {logic [ADDR_W-1:0] a; sbs_wr_ctl_t w; logic [DATA_W-1:0] d, e;} sbs_row_t;
   logic clk = 0, rst_n = 0, oe_n = 0, mode = 1, sleep_req = 0, tck = 0, tdi = 0;
   logic [ADDR_W-1:0] addr;
   logic [5:0] ctl;
   sbs_wr_ctl_t wr;
   logic [DATA_W-1:0] din, dout;
   logic doe_n, slp, tdo, tdo_oe_n;
   int n_mismatch = 0, checks = 0;
   localparam logic [ADDR_W-1:0] B = 19'h0_0100;
   sbs_row_t rows[5] = '{'{19'h0_0010, 6'h1F, 36'h1_2345_6789, 36'h1_2345_6789},
      '{19'h0_0011, 6'h2E, 36'h0, 36'hF_FFFF_FE00}, '{19'h0_0012, 6'h25, 36'h0, 36'h0_07FC_01FF},
      '{19'h0_0013, 6'h30, 36'h0, 36'hF_FFFF_FFFF}, '{19'h4_0000, 6'h0E, 36'h0, 36'h0}};
   always #12.5 clk = ~clk;
   sbs_bus_model i_sbs_bus_model (.clk(clk), .addr(addr), .ctl(ctl), .wr(wr), .data_in(din));
   sbs_port i_sbs_port (.clk(clk), .rst_n(rst_n), .addr(addr), .proc_addr_strobe_n(ctl[5]),
      .ctrl_addr_strobe_n(ctl[4]), .burst_advance_n(ctl[3]), .chip_sel_a_n(ctl[2]),
      .chip_sel_b(ctl[1]), .chip_sel_c_n(ctl[0]), .global_write_n(wr.global_n),
      .byte_write_en_n(wr.byte_en_n), .lane0_write_sel_n(wr.lane_sel_n[0]),
      .lane1_write_sel_n(wr.lane_sel_n[1]), .lane2_write_sel_n(wr.lane_sel_n[2]),
      .lane3_write_sel_n(wr.lane_sel_n[3]), .out_en_n(oe_n), .burst_mode(mode),
      .sleep_req(sleep_req), .data_in(din), .data_out(dout), .data_oe_n(doe_n),
      .sleep_active(slp), .test_clk(tck), .test_data_in(tdi), .test_data_out(tdo),
      .test_data_oe_n(tdo_oe_n));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string n, logic [DATA_W-1:0] e, g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(string n, logic e, g);
      chk(n, DATA_W'(e), DATA_W'(g));
   endtask
   task automatic wrg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, sbs_wr_ctl_t w);
      i_sbs_bus_model.drive(6'h2A, w, a, d);
   endtask
   task automatic rd(logic [ADDR_W-1:0] a, logic [5:0] c = 6'h1A);
      i_sbs_bus_model.drive(c, 6'h3F, a, '0);
   endtask
   task automatic idle(logic [5:0] c = 6'h3A);
      i_sbs_bus_model.drive(c, 6'h3F, '0, '0);
   endtask
   task automatic burst(logic m);
      logic [1:0] o;
      rst_n = 0;
      mode = m;
      repeat (8) @(posedge clk);
      #1 rst_n = 1;
      for (int k = 0; k < 4; k++) wrg(B + 19'(k), 36'(k), 6'h1F);
      rd(B + 1);
      for (int j = 0; j < 4; j++) begin
         idle(j < 3 ? 6'h32 : 6'h3A);
         o = m ? 2'h1 ^ j[1:0] : 2'(2'h1 + j[1:0]);
         chk("burst", {34'h0, o}, dout);
      end
   endtask
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      burst(1'b1);
      foreach (rows[i]) begin
         wrg(rows[i].a, '1, 6'h1F);
         wrg(rows[i].a, rows[i].d, rows[i].w);
         rd(rows[i].a);
         idle();
         chk("row", rows[i].e, dout);
      end
      burst(1'b0);
      i_sbs_bus_model.drive(6'h0A, 6'h1F, B + 2, 36'h5);
      rd(B + 2);
      idle();
      chk("both strobes", 36'h2, dout);
      rd(B + 3, 6'h1E);
      idle();
      chk("unselected strobe", 36'h2, dout);
      chkb("unselected hold", 1'b0, doe_n);
      rd(B + 3, 6'h28);
      rd(B + 3);
      chk("deselect", 36'h2, dout);
      rd(B + 3);
      chkb("mask", 1'b1, doe_n);
      idle();
      chkb("drive", 1'b0, doe_n);
      chk("read", 36'h3, dout);
      @(posedge clk);
      #1 oe_n = 1;
      #1 chkb("enable off", 1'b1, doe_n);
      @(posedge clk);
      #1 oe_n = 0;
      rd(B);
      i_sbs_bus_model.drive(6'h3A, 6'h1F, B, 36'h0_ABCD_0123);
      chkb("write float", 1'b1, doe_n);
      idle();
      rd(B);
      idle();
      chk("proc write", 36'h0_ABCD_0123, dout);
      @(posedge clk);
      #1 sleep_req = 1;
      #1 chkb("sleep", 1'b1, slp);
      chkb("sleep float", 1'b1, doe_n);
      repeat (4) idle(6'h38);
      @(posedge clk);
      #1 sleep_req = 0;
      repeat (2) idle(6'h38);
      rd(B);
      idle();
      chk("retain", 36'h0_ABCD_0123, dout);
      @(posedge clk);
      #1 tdi = 1;
      tck = 1;
      repeat (8) @(posedge clk);
      #1 chkb("scan early", 1'b0, tdo);
      tck = 0;
      repeat (8) @(posedge clk);
      #1 chkb("scan", 1'b1, tdo);
      chkb("scan enable", 1'b0, tdo_oe_n);
      print_verdict();
   end
endmodule // tb_top
